// ===== hw/mcg_pkg.sv
/*
 * mcg_pkg: shared constants and types of the main synchronous clock unit.
 * Assumes one system clock; every divided rate leaves the unit as an enable pulse.
 */
`default_nettype none

package mcg_pkg;

    // widths and counts
    localparam int DIV_WIDTH       = 8;
    localparam int PRESCALE_WIDTH  = 8;
    localparam int SYS_CLK_COUNT   = 8;
    localparam int PER_CLK_COUNT   = 16;
    localparam int DOMAIN_COUNT    = 3;
    localparam int WRITE_WIDTH     = 32;

    // domain indices
    localparam int DOM_CPU         = 0;
    localparam int DOM_LP          = 1;
    localparam int DOM_BUP         = 2;

    // divider codes and reset values
    localparam logic [DIV_WIDTH-1:0] DIV_ONE       = 8'h01;
    localparam logic [DIV_WIDTH-1:0] CPU_DIV_RESET = 8'h01;
    localparam logic [DIV_WIDTH-1:0] LP_DIV_RESET  = 8'h01;
    localparam logic [DIV_WIDTH-1:0] BUP_DIV_RESET = 8'h01;

    // prescaler phase where every divided clock ticks together
    localparam logic [PRESCALE_WIDTH-1:0] ALIGN_MASK = 8'h7F;
    localparam logic [PRESCALE_WIDTH-1:0] COUNT_STEP = 8'h01;

    // gating masks: reset values and special positions
    localparam logic [SYS_CLK_COUNT-1:0] SYS_MASK_RESET = 8'hFF;
    localparam logic [PER_CLK_COUNT-1:0] PER_MASK_RESET = 16'hFFFF;
    localparam logic [PER_CLK_COUNT-1:0] PER_BACKUP_MAP = 16'h000F;
    localparam int BRIDGE_SYS_BIT  = 0;
    localparam int OWN_PER_BIT     = 4;

    // interrupt bits
    localparam int  READY_BIT          = 0;
    localparam logic IRQ_FLAG_RESET    = 1'b1;
    localparam logic IRQ_ENABLE_RESET  = 1'b0;

    // register targets of a write request
    typedef enum logic [2:0] {
        TGT_IRQ_ENABLE_CLEAR,
        TGT_IRQ_ENABLE_SET,
        TGT_IRQ_FLAGS,
        TGT_CPU_DIV,
        TGT_LP_DIV,
        TGT_BUP_DIV,
        TGT_SYS_MASK,
        TGT_PER_MASK
    } mcg_target_type;

    // one register write, valid for one cycle
    typedef struct packed {
        logic                   valid;
        logic                   from_debugger;
        mcg_target_type         target;
        logic [WRITE_WIDTH-1:0] data;
    } mcg_write_type;

    // divider change sequencing
    typedef enum logic {
        ST_READY,
        ST_PENDING
    } mcg_state_type;

    // a legal divider code has exactly one bit set
    function automatic logic mcg_is_onehot(input logic [DIV_WIDTH-1:0] code);
        return (code != '0) && ((code & (code - DIV_ONE)) == '0);
    endfunction

endpackage

`default_nettype wire

// ===== hw/mcg_tick_sel.sv
/*
 * mcg_tick_sel: picks one divided tick out of the shared prescaler count.
 * Assumes the divider code is one-hot; the caller only ever feeds legal codes.
 */
`default_nettype none

module mcg_tick_sel
    import mcg_pkg::*;
(
    input  wire logic [PRESCALE_WIDTH-1:0] count,    // shared prescaler count
    input  wire logic [DIV_WIDTH-1:0]      div_code, // one-hot division factor
    output logic                           tick      // high one cycle per period
);

    // tick whenever the low bits below the divider are all zero
    always_comb begin
        tick = ((count & (div_code - DIV_ONE)) == '0);
    end

endmodule

`default_nettype wire

// ===== hw/mcg_main_clock.sv
/*
 * mcg_main_clock: main synchronous clock unit with shared prescaler, three
 * clock domains, gated bus clock enables, clock-ready flag and interrupt.
 * Assumes sys_clk is the main source clock and all inputs share its domain.
 */
// Notes on behaviour
// - one shared 8-bit prescaler feeds all clocks
// - stopped CPU clock gives no edges
// - bus clocks synchronous, run during sleep
// - individual gate per module bus clock
// - three domains: CPU, low power, backup
// - debug keeps clocks running during sleep
// - guard blocks writes except flags, debugger
// - after reset all domains undivided
// - no enable, no module reset
// - CPU frequency is main over divider
// - forbidden divider stored, unused, violation reported; backup divider: stored, unused, no violation
// - new divider applied to domain simultaneously
// - clock ready low until setting effective; backup divider changes leave it high
// - interrupt raised when setting becomes effective; backup divider changes raise none
// - mask bits stop or start bus clocks
// - masked peripheral registers inaccessible
// - own clock masked locks mask registers
// - clock ready interrupt is wake source
// - enable set/clear by writing one
// - request while flag and enable set
// - CPU divider one-hot 1..128, reset 1
`default_nettype none

module mcg_main_clock
    import mcg_pkg::*;
(
    input  wire logic                     sys_clk,            // main source clock
    input  wire logic                     rst_b,              // system reset, low
    input  wire mcg_write_type            reg_write,          // register write request
    input  wire logic                     access_guard_lock,  // write protection on
    input  wire logic                     sleep_req,          // sleep, CPU clock off
    input  wire logic                     debug_mode,         // debugger attached
    output logic                          cpu_clk_en,         // CPU clock enable
    output logic                          lp_clk_en,          // low-power domain enable
    output logic                          bup_clk_en,         // backup domain enable
    output logic [SYS_CLK_COUNT-1:0]      sys_bus_clk_en,     // system bus clock enables
    output logic [PER_CLK_COUNT-1:0]      per_bus_clk_en,     // peripheral bus enables
    output logic [PER_CLK_COUNT-1:0]      per_access_en,      // peripheral register access
    output logic [DIV_WIDTH-1:0]          processor_divider,  // stored CPU divider
    output logic [DIV_WIDTH-1:0]          lowpower_divider,   // stored LP divider
    output logic [DIV_WIDTH-1:0]          backup_divider,     // stored backup divider
    output logic [SYS_CLK_COUNT-1:0]      system_clock_mask,  // system bus mask
    output logic [PER_CLK_COUNT-1:0]      peripheral_clock_mask, // peripheral mask
    output logic                          clock_ready,        // settings in effect
    output logic                          irq_flags,          // sticky ready flag
    output logic                          irq_enable,         // ready interrupt enable
    output logic                          irq_request,        // interrupt request
    output logic                          wake_request,       // synchronous wake-up
    output logic                          access_violation    // pulse to access guard
);

    // prescaler state
    logic [PRESCALE_WIDTH-1:0] count;
    logic [PRESCALE_WIDTH-1:0] next_count;
    logic                      align;

    // control state
    mcg_state_type             state;
    mcg_state_type             next_state;
    logic [DIV_WIDTH-1:0]      eff_div [DOMAIN_COUNT];
    logic [DIV_WIDTH-1:0]      next_eff_div [DOMAIN_COUNT];
    logic [DIV_WIDTH-1:0]      pend_div [DOMAIN_COUNT];
    logic [DIV_WIDTH-1:0]      next_pend_div [DOMAIN_COUNT];
    logic [DIV_WIDTH-1:0]      next_processor_divider;
    logic [DIV_WIDTH-1:0]      next_lowpower_divider;
    logic [DIV_WIDTH-1:0]      next_backup_divider;
    logic [SYS_CLK_COUNT-1:0]  next_system_clock_mask;
    logic [PER_CLK_COUNT-1:0]  next_peripheral_clock_mask;
    logic                      mask_lock;
    logic                      next_mask_lock;
    logic                      next_clock_ready;
    logic                      next_irq_flags;
    logic                      next_irq_enable;
    logic                      next_access_violation;
    logic                      wr_ok;
    logic [DIV_WIDTH-1:0]      wr_div;
    logic                      div_legal;

    // output next values
    logic [DOMAIN_COUNT-1:0]   tick;
    logic                      next_cpu_clk_en;
    logic [SYS_CLK_COUNT-1:0]  next_sys_bus_clk_en;
    logic [PER_CLK_COUNT-1:0]  next_per_bus_clk_en;
    logic                      next_irq_request;

    // free-running prescaler, one shared count for every domain
    always_comb begin
        next_count = count + COUNT_STEP;
        align      = ((count & ALIGN_MASK) == '0);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // one tick selector per domain, all reading the same count
    genvar gd;
    generate
        for (gd = 0; gd < DOMAIN_COUNT; gd++) begin : g_domain
            mcg_tick_sel u_tick (
                .count    (count),
                .div_code (eff_div[gd]),
                .tick     (tick[gd])
            );
        end
    endgenerate

    // register writes, divider sequencing, flag and enable
    always_comb begin
        next_state                 = state;
        next_eff_div               = eff_div;
        next_pend_div              = pend_div;
        next_processor_divider     = processor_divider;
        next_lowpower_divider      = lowpower_divider;
        next_backup_divider        = backup_divider;
        next_system_clock_mask     = system_clock_mask;
        next_peripheral_clock_mask = peripheral_clock_mask;
        next_clock_ready           = clock_ready;
        next_irq_flags             = irq_flags;
        next_irq_enable            = irq_enable;
        next_access_violation      = 1'b0;
        wr_div                     = reg_write.data[DIV_WIDTH-1:0];
        div_legal                  = 1'b0;
        // flags stay writable under the guard; debugger writes bypass it
        wr_ok = reg_write.valid && (reg_write.from_debugger || !access_guard_lock
                || (reg_write.target == TGT_IRQ_FLAGS));
        // losing the own bus clock or the bridge freezes the masks for good
        next_mask_lock = mask_lock || !system_clock_mask[BRIDGE_SYS_BIT]
                         || !peripheral_clock_mask[OWN_PER_BIT];
        // applying only on the common phase keeps all clocks in step
        if (align) begin
            next_eff_div = pend_div;
        end
        if (wr_ok) begin
            case (reg_write.target)
                TGT_IRQ_ENABLE_CLEAR: begin
                    if (reg_write.data[READY_BIT]) begin
                        next_irq_enable = 1'b0;
                    end
                end
                TGT_IRQ_ENABLE_SET: begin
                    if (reg_write.data[READY_BIT]) begin
                        next_irq_enable = 1'b1;
                    end
                end
                TGT_IRQ_FLAGS: begin
                    if (reg_write.data[READY_BIT]) begin
                        next_irq_flags = 1'b0;
                    end
                end
                TGT_CPU_DIV: begin
                    next_processor_divider = wr_div;
                    div_legal = mcg_is_onehot(wr_div) && (wr_div <= pend_div[DOM_LP]);
                    if (state == ST_PENDING) begin
                        next_access_violation = 1'b1;
                    end else if (!div_legal) begin
                        next_access_violation = 1'b1;
                    end else begin
                        next_pend_div[DOM_CPU] = wr_div;
                        next_state             = ST_PENDING;
                        next_clock_ready       = 1'b0;
                    end
                end
                TGT_LP_DIV: begin
                    next_lowpower_divider = wr_div;
                    div_legal = mcg_is_onehot(wr_div) && (wr_div >= pend_div[DOM_CPU])
                                && (wr_div <= pend_div[DOM_BUP]);
                    if (state == ST_PENDING) begin
                        next_access_violation = 1'b1;
                    end else if (!div_legal) begin
                        next_access_violation = 1'b1;
                    end else begin
                        next_pend_div[DOM_LP] = wr_div;
                        next_state            = ST_PENDING;
                        next_clock_ready      = 1'b0;
                    end
                end
                TGT_BUP_DIV: begin
                    // backup changes do not drop the ready flag
                    next_backup_divider = wr_div;
                    div_legal = mcg_is_onehot(wr_div) && (wr_div >= pend_div[DOM_LP]);
                    if (div_legal) begin
                        next_pend_div[DOM_BUP] = wr_div;
                    end
                end
                TGT_SYS_MASK: begin
                    if (!mask_lock) begin
                        next_system_clock_mask = reg_write.data[SYS_CLK_COUNT-1:0];
                    end
                end
                TGT_PER_MASK: begin
                    if (!mask_lock) begin
                        next_peripheral_clock_mask = reg_write.data[PER_CLK_COUNT-1:0];
                    end
                end
                default: next_access_violation = 1'b0;
            endcase
        end
        // the setting lands on the aligned edge; the flag set beats a clear
        case (state)
            ST_PENDING: begin
                if (align) begin
                    next_state       = ST_READY;
                    next_clock_ready = 1'b1;
                    next_irq_flags   = 1'b1;
                end
            end
            ST_READY: next_state = next_state;
            default: next_state = ST_READY;
        endcase
    end

    // no enable and no module reset: only the system reset touches this state
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state                 <= ST_READY;
            eff_div               <= '{CPU_DIV_RESET, LP_DIV_RESET, BUP_DIV_RESET};
            pend_div              <= '{CPU_DIV_RESET, LP_DIV_RESET, BUP_DIV_RESET};
            processor_divider     <= CPU_DIV_RESET;
            lowpower_divider      <= LP_DIV_RESET;
            backup_divider        <= BUP_DIV_RESET;
            system_clock_mask     <= SYS_MASK_RESET;
            peripheral_clock_mask <= PER_MASK_RESET;
            mask_lock             <= 1'b0;
            clock_ready           <= 1'b1;
            irq_flags             <= IRQ_FLAG_RESET;
            irq_enable            <= IRQ_ENABLE_RESET;
            access_violation      <= 1'b0;
        end else begin
            state                 <= next_state;
            eff_div               <= next_eff_div;
            pend_div              <= next_pend_div;
            processor_divider     <= next_processor_divider;
            lowpower_divider      <= next_lowpower_divider;
            backup_divider        <= next_backup_divider;
            system_clock_mask     <= next_system_clock_mask;
            peripheral_clock_mask <= next_peripheral_clock_mask;
            mask_lock             <= next_mask_lock;
            clock_ready           <= next_clock_ready;
            irq_flags             <= next_irq_flags;
            irq_enable            <= next_irq_enable;
            access_violation      <= next_access_violation;
        end
    end

    // clock enables; bus clocks ignore sleep, debug keeps the CPU clock alive
    always_comb begin
        next_cpu_clk_en  = tick[DOM_CPU] && (!sleep_req || debug_mode);
        next_irq_request = next_irq_flags && next_irq_enable;
    end

    genvar gs;
    generate
        for (gs = 0; gs < SYS_CLK_COUNT; gs++) begin : g_sys_gate
            assign next_sys_bus_clk_en[gs] = tick[DOM_CPU] && system_clock_mask[gs];
        end
        for (gs = 0; gs < PER_CLK_COUNT; gs++) begin : g_per_gate
            assign next_per_bus_clk_en[gs] = peripheral_clock_mask[gs]
                && (PER_BACKUP_MAP[gs] ? tick[DOM_BUP] : tick[DOM_LP]);
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            {cpu_clk_en, lp_clk_en, bup_clk_en}             <= '0;
            {sys_bus_clk_en, per_bus_clk_en, per_access_en} <= '0;
            {irq_request, wake_request}                     <= '0;
        end else begin
            cpu_clk_en     <= next_cpu_clk_en;
            lp_clk_en      <= tick[DOM_LP];
            bup_clk_en     <= tick[DOM_BUP];
            sys_bus_clk_en <= next_sys_bus_clk_en;
            per_bus_clk_en <= next_per_bus_clk_en;
            per_access_en  <= next_peripheral_clock_mask;
            irq_request    <= next_irq_request;
            wake_request   <= next_irq_request;
        end
    end

    // checks on dividers, ready flag, interrupt, sleep, guard and mask lock
    AST_ILLEGAL_KEEPS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_ok && reg_write.target == TGT_CPU_DIV && !mcg_is_onehot(wr_div)
        |=> pend_div[DOM_CPU] == $past(pend_div[DOM_CPU]) && access_violation)
        else $error("forbidden divider reached pending setting");
    AST_BUSY_REWRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_ok && reg_write.target == TGT_LP_DIV && state == ST_PENDING
        |=> access_violation)
        else $error("rewrite while not ready not reported");
    AST_READY_DROPS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_ok && reg_write.target == TGT_CPU_DIV && state == ST_READY && div_legal
        |=> !clock_ready ##[1:128] clock_ready)
        else $error("ready flag did not drop and recover");
    AST_APPLY_ALIGNED: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(clock_ready) |-> eff_div[DOM_CPU] == pend_div[DOM_CPU]
        && eff_div[DOM_LP] == pend_div[DOM_LP] && (count & ALIGN_MASK) == COUNT_STEP)
        else $error("divider applied off the common phase");
    AST_IRQ_ON_READY: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(clock_ready) && irq_enable |-> irq_request && irq_flags)
        else $error("no interrupt when setting took effect");
    AST_ENABLE_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_ok && reg_write.target == TGT_IRQ_ENABLE_CLEAR && reg_write.data[READY_BIT]
        |=> !irq_enable && !irq_request)
        else $error("enable clear left request active");
    AST_CPU_STOPPED: assert property (@(posedge sys_clk) disable iff (!rst_b)
        sleep_req && !debug_mode |=> !cpu_clk_en)
        else $error("CPU clock ticked during sleep");
    AST_BUS_IN_SLEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
        sleep_req && tick[DOM_CPU] && system_clock_mask[BRIDGE_SYS_BIT]
        |=> sys_bus_clk_en[BRIDGE_SYS_BIT])
        else $error("bus clock stopped during sleep");
    AST_GUARD_BLOCKS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_write.valid && access_guard_lock && !reg_write.from_debugger
        && reg_write.target == TGT_CPU_DIV |=> $stable(processor_divider))
        else $error("protected divider write went through");
    AST_MASK_LOCKED: assert property (@(posedge sys_clk) disable iff (!rst_b)
        mask_lock |=> $stable(peripheral_clock_mask) && $stable(system_clock_mask) && mask_lock)
        else $error("mask changed after lock");
    AST_RESET_UNDIVIDED: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(rst_b) |-> eff_div[DOM_CPU] == DIV_ONE && eff_div[DOM_BUP] == DIV_ONE)
        else $error("domains divided after reset");

endmodule

`default_nettype wire

// ===== sim/mcg_clock_sink.sv
/*
 * mcg_clock_sink: clock consumers on the far side of the clock unit.
 * Assumes every enable is sampled at the sys_clk rising edge.
 */
`default_nettype none

module mcg_clock_sink (
    input  wire logic sys_clk, // main clock
    input  wire logic cpu_en,  // cpu clock enable
    input  wire logic bus_en,  // one system bus enable
    input  wire logic lp_en,   // low-power peripheral enable
    input  wire logic bup_en,  // backup peripheral enable
    output var  int   n_cpu,   // instructions executed
    output var  int   n_bus,   // bus ticks seen
    output var  int   n_lp,    // low-power peripheral ticks
    output var  int   n_bup    // backup peripheral ticks
);
    timeunit 1ns;
    timeprecision 1ns;

    // consumers start idle; an unknown enable counts as no edge
    initial begin
        {n_cpu, n_bus, n_lp, n_bup} = '0;
    end

    // each consumer only advances on its own enable
    always @(posedge sys_clk) begin
        if (cpu_en === 1'b1) n_cpu <= n_cpu + 1;
        if (bus_en === 1'b1) n_bus <= n_bus + 1;
        if (lp_en === 1'b1) n_lp <= n_lp + 1;
        if (bup_en === 1'b1) n_bup <= n_bup + 1;
    end
endmodule

`default_nettype wire

// ===== sim/tb_main_sync_clock_divider_gater.sv
/*
 * tb_main_sync_clock_divider_gater: self-checking bench of the clock unit.
 * Assumes the unit and a clock sink model; counts enables over 256 cycles.
 */
`default_nettype none

module tb_main_sync_clock_divider_gater;
    import mcg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk = 0, rst_b = 0, access_guard_lock = 0, sleep_req = 0, debug_mode = 0;
    mcg_write_type reg_write = '0;
    logic cpu_clk_en, lp_clk_en, bup_clk_en, clock_ready, irq_flags, irq_enable;
    logic irq_request, wake_request, access_violation;
    logic [7:0] sys_bus_clk_en, processor_divider, lowpower_divider, backup_divider;
    logic [7:0] system_clock_mask, d;
    logic [15:0] per_bus_clk_en, per_access_en, peripheral_clock_mask;
    int fails = 0, n_checks = 0, n_cpu, n_bus, n_lp, n_bup, c0, b0, l0, p0;
    int n_lpe = 0, n_bue = 0, slow = 1;
    logic busy;

    mcg_main_clock u_mcg_main_clock (.*);
    mcg_clock_sink u_mcg_clock_sink (.sys_clk(sys_clk), .cpu_en(cpu_clk_en),
        .bus_en(sys_bus_clk_en[1]), .lp_en(per_bus_clk_en[5]), .bup_en(per_bus_clk_en[0]),
        .n_cpu(n_cpu), .n_bus(n_bus), .n_lp(n_lp), .n_bup(n_bup));

    always #20 sys_clk = ~sys_clk;

    // ungated domain enables, counted beside the sink's gated ones
    always @(posedge sys_clk) begin
        if (lp_clk_en === 1'b1) n_lpe <= n_lpe + 1;
        if (bup_clk_en === 1'b1) n_bue <= n_bue + 1;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one write, then an idle edge so valid never toggles twice in a step
    task automatic wr(mcg_target_type t, logic [31:0] v, logic dbg);
        @(posedge sys_clk);
        reg_write <= '{1'b1, dbg, t, v};
        // ready as it stands through the taking edge
        #1;
        busy = (clock_ready !== 1'b1);
        @(posedge sys_clk);
        reg_write.valid <= 1'b0;
        #1;
    endtask

    // apply happens within one 128-cycle alignment period
    task automatic wait_ready();
        for (int i = 0; i < 300 && clock_ready !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (clock_ready !== 1'b1) begin
            fails++;
            conclude();
        end
    endtask

    // pulses seen by each consumer over 256 cycles
    task automatic run(int ec, int eb, int el, int ep);
        int r0;
        int u0;
        // one settling edge: gated enables follow a mask write a cycle late
        @(posedge sys_clk);
        #1;
        {c0, b0, l0, p0} = {n_cpu, n_bus, n_lp, n_bup};
        {r0, u0} = {n_lpe, n_bue};
        repeat (256) @(posedge sys_clk);
        #1;
        chk(n_cpu - c0, ec);
        chk(n_bus - b0, eb);
        chk(n_lp - l0, el);
        chk(n_bup - p0, ep);
        chk(n_lpe - r0, 256 / slow);
        chk(n_bue - u0, 256 / slow);
    endtask

    initial begin
        d = 8'($urandom(81));
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({processor_divider, lowpower_divider, backup_divider}, 24'h01_0101);
        chk({system_clock_mask, peripheral_clock_mask}, 24'hFF_FFFF);
        chk({clock_ready, irq_flags, irq_enable}, 3'b110);
        run(256, 256, 256, 256);
        wr(TGT_IRQ_ENABLE_SET, 32'h0, 1'b0);
        chk(irq_enable, 1'b0);
        wr(TGT_IRQ_ENABLE_SET, 32'h1, 1'b0);
        chk({irq_request, wake_request}, 2'b11);
        wr(TGT_IRQ_FLAGS, 32'h1, 1'b0);
        chk(irq_request, 1'b0);
        // slow domains first so every cpu code keeps the frequency order
        wr(TGT_BUP_DIV, 32'h80, 1'b0);
        repeat (130) @(posedge sys_clk);
        wr(TGT_LP_DIV, 32'h80, 1'b0);
        chk(clock_ready, 1'b0);
        slow = 128;
        wait_ready();
        chk(irq_request, 1'b1);
        repeat (4) begin
            d = 8'h01 << ($urandom % 8);
            wr(TGT_CPU_DIV, {24'h0, d}, 1'b0);
            chk({processor_divider, clock_ready}, {d, 1'b0});
            wait_ready();
            run(256 / d, 256 / d, 2, 2);
        end
        wr(TGT_CPU_DIV, 32'h03, 1'b0);
        chk({processor_divider, access_violation}, {8'h03, 1'b1});
        run(256 / d, 256 / d, 2, 2);
        wr(TGT_CPU_DIV, 32'h02, 1'b0);
        d = 8'h02;
        // rewrite of the same order; next to an apply edge it may be taken
        wr(TGT_LP_DIV, 32'h80, 1'b0);
        chk(access_violation, busy);
        wait_ready();
        @(posedge sys_clk) access_guard_lock <= 1'b1;
        wr(TGT_CPU_DIV, 32'h01, 1'b0);
        chk({processor_divider, access_violation}, {8'h02, 1'b0});
        wr(TGT_IRQ_FLAGS, 32'h1, 1'b0);
        chk(irq_flags, 1'b0);
        wr(TGT_SYS_MASK, 32'hFD, 1'b1);
        chk(system_clock_mask, 8'hFD);
        @(posedge sys_clk) access_guard_lock <= 1'b0;
        run(128, 0, 2, 2);
        wr(TGT_SYS_MASK, 32'hFF, 1'b0);
        @(posedge sys_clk) sleep_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        run(0, 128, 2, 2);
        @(posedge sys_clk) debug_mode <= 1'b1;
        repeat (2) @(posedge sys_clk);
        run(128, 128, 2, 2);
        @(posedge sys_clk) {sleep_req, debug_mode} <= 2'b00;
        wr(TGT_PER_MASK, 32'hFFDF, 1'b0);
        chk(per_access_en, 16'hFFDF);
        run(128, 128, 0, 2);
        wr(TGT_PER_MASK, 32'hFFFF, 1'b0);
        chk(per_access_en, 16'hFFFF);
        // masking the unit's own register clock locks the masks
        wr(TGT_PER_MASK, 32'hFFEF, 1'b0);
        wr(TGT_PER_MASK, 32'hFFFF, 1'b0);
        chk(peripheral_clock_mask, 16'hFFEF);
        @(posedge sys_clk) rst_b <= 1'b0;
        @(posedge sys_clk) rst_b <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({peripheral_clock_mask, processor_divider}, 24'hFFFF_01);
        conclude();
    end
endmodule

`default_nettype wire
